// [hw/sfa_ctrl.sv]
// Controller: AXI4-Lite commanded mass erase sequencer driving the CPU bus
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
module sfa_ctrl
  import sfa_pkg::*;
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  // AXI4-Lite slave
  input  wire logic [3:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [3:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Device bus
  sfa_if.ctrl              bus
);
  typedef enum logic [3:0] {
    SFA_S_IDLE  = 4'h0, SFA_S_SEL   = 4'h1, SFA_S_RDP  = 4'h2, SFA_S_LATCH = 4'h3,
    SFA_S_SETUP = 4'h4, SFA_S_HVON  = 4'h5, SFA_S_ERASE = 4'h6, SFA_S_CLR  = 4'h7,
    SFA_S_HOLD  = 4'h8, SFA_S_HVOFF = 4'h9, SFA_S_RECOV = 4'ha, SFA_S_CHK  = 4'hb
  } sfa_state_t;

  typedef struct packed {
    sfa_state_t      fsm;
    logic [SFA_CNT_W-1:0] cnt;
    logic            busy, done, fail;
    logic [1:0]      cmd;
    logic [15:0]     addr;
    logic [7:0]      prot;
    logic            req, we;
    logic [15:0]     baddr;
    logic [7:0]      bdata;
    logic            awr, wr_ok, bvalid, arr, rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } sfa_ctrl_st_t;

  sfa_ctrl_st_t st_r;
  sfa_ctrl_st_t st_nxt;

  function automatic logic [7:0] ctl(input logic p, input logic e, input logic w, input logic h);
    ctl = 8'h00;
    ctl[SFA_BIT_PROG]  = p;
    ctl[SFA_BIT_ERASE] = e;
    ctl[SFA_BIT_WHOLE] = w;
    ctl[SFA_BIT_HIGH_VOLTAGE_ENABLE]  = h;
  endfunction

  always_comb begin
    st_nxt = st_r;
    // Bus handshake: drop request once acknowledged
    if (st_r.req && bus.ack) st_nxt.req = 1'b0;
    if (st_r.bvalid && i_bready) st_nxt.bvalid = 1'b0;
    if (st_r.rvalid && i_rready) st_nxt.rvalid = 1'b0;
    if (i_awvalid && !st_r.awr && !st_r.bvalid) st_nxt.awr = 1'b1;
    if (st_r.awr && i_wvalid && !st_r.bvalid) begin
      st_nxt.awr    = 1'b0;
      st_nxt.bvalid = 1'b1;
      if (i_awaddr == SFA_AX_CMD && !st_r.busy && i_wstrb[0]) begin
        st_nxt.cmd  = i_wdata[1:0];
        st_nxt.busy = (i_wdata[1:0] == SFA_CMD_WHOLE);
        st_nxt.done = 1'b0;
        st_nxt.fail = 1'b0;
      end else if (i_awaddr == SFA_AX_ADDR && !st_r.busy && i_wstrb[0]) begin
        st_nxt.addr = i_wdata[15:0];
      end
    end
    if (i_arvalid && !st_r.arr && !st_r.rvalid) st_nxt.arr = 1'b1;
    if (st_r.arr) begin
      st_nxt.arr    = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = SFA_RESP_OKAY;
      case (i_araddr)
        SFA_AX_CMD:  st_nxt.rdata = {30'h0, st_r.cmd};
        SFA_AX_STAT: st_nxt.rdata = {21'h0, st_r.prot, st_r.fail, st_r.done, st_r.busy};
        SFA_AX_ADDR: st_nxt.rdata = {16'h0, st_r.addr};
        default: begin
          st_nxt.rdata = 32'h0;
          st_nxt.rresp = SFA_RESP_SLVERR;
        end
      endcase
    end
    // Sequencer: at most one device access per step; LATCH, CLR, HVOFF and a passing ERASE then load a timed wait
    // Sequence runs in fabric, never from the array itself
    if (!st_r.req && !bus.ack) begin
      if (st_r.cnt != '0) st_nxt.cnt = st_r.cnt - 1'b1;
      else begin
        case (st_r.fsm)
          SFA_S_IDLE: if (st_r.busy) st_nxt.fsm = SFA_S_SEL;
          SFA_S_SEL: begin
            st_nxt = issue(st_nxt, 1'b1, SFA_CTRL_ADDR, ctl(1'b0, 1'b1, 1'b1, 1'b0));
            st_nxt.fsm = SFA_S_RDP;
          end
          SFA_S_RDP: begin
            st_nxt = issue(st_nxt, 1'b0, SFA_PROT_ADDR, 8'h00);
            st_nxt.fsm = SFA_S_LATCH;
          end
          SFA_S_LATCH: begin
            st_nxt.prot = bus.rdata;
            st_nxt = issue(st_nxt, 1'b1, st_r.addr, 8'h00);
            st_nxt.fsm = SFA_S_HVON;
            st_nxt.cnt = SFA_CNT_W'(SFA_SETUP_CYC);
          end
          SFA_S_HVON: begin
            st_nxt = issue(st_nxt, 1'b1, SFA_CTRL_ADDR, ctl(1'b0, 1'b1, 1'b1, 1'b1));
            st_nxt.fsm = SFA_S_CHK;
          end
          SFA_S_CHK: begin
            st_nxt = issue(st_nxt, 1'b0, SFA_CTRL_ADDR, 8'h00);
            st_nxt.fsm = SFA_S_ERASE;
          end
          SFA_S_ERASE: begin
            if (!bus.rdata[SFA_BIT_HIGH_VOLTAGE_ENABLE]) begin
              st_nxt.fail = 1'b1;
              st_nxt = issue(st_nxt, 1'b1, SFA_CTRL_ADDR, 8'h00);
              st_nxt.fsm = SFA_S_RECOV;
            end else begin
              st_nxt.cnt = SFA_CNT_W'(SFA_WHOLE_CYC);
              st_nxt.fsm = SFA_S_CLR;
            end
          end
          SFA_S_CLR: begin
            st_nxt = issue(st_nxt, 1'b1, SFA_CTRL_ADDR, ctl(1'b0, 1'b0, 1'b0, 1'b1));
            st_nxt.cnt = SFA_CNT_W'(SFA_HOLD_CYC);
            st_nxt.fsm = SFA_S_HVOFF;
          end
          SFA_S_HVOFF: begin
            st_nxt = issue(st_nxt, 1'b1, SFA_CTRL_ADDR, 8'h00);
            st_nxt.cnt = SFA_CNT_W'(SFA_RECOV_CYC);
            st_nxt.fsm = SFA_S_RECOV;
          end
          SFA_S_RECOV: begin
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
            st_nxt.fsm  = SFA_S_IDLE;
          end
          default: st_nxt.fsm = SFA_S_IDLE;
        endcase
      end
    end
    if (i_reset) begin
      st_nxt     = '0;
      st_nxt.fsm = SFA_S_IDLE;
    end
  end

  function automatic sfa_ctrl_st_t issue(input sfa_ctrl_st_t s, input logic w,
                                         input logic [15:0] a, input logic [7:0] d);
    issue       = s;
    issue.req   = 1'b1;
    issue.we    = w;
    issue.baddr = a;
    issue.bdata = d;
  endfunction

  always_ff @(posedge i_mclk) begin
    st_r <= st_nxt;
  end

  assign o_awready = st_r.awr && i_wvalid;
  assign o_wready  = st_r.awr && i_wvalid;
  assign o_bvalid  = st_r.bvalid;
  assign o_bresp   = SFA_RESP_OKAY;
  assign o_arready = st_r.arr;
  assign o_rvalid  = st_r.rvalid;
  assign o_rdata   = st_r.rdata;
  assign o_rresp   = st_r.rresp;
  assign bus.req   = st_r.req;
  assign bus.we    = st_r.we;
  assign bus.addr  = st_r.baddr;
  assign bus.wdata = st_r.bdata;
endmodule // sfa_ctrl

// [hw/sfa_dev.sv]
// Second flash array control: control register, protection, mass erase
`timescale 1ns/1ps
module sfa_dev
  import sfa_pkg::*;
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  // CPU bus
  sfa_if.dev               bus,
  // Other array: protect byte storage and vector page erase
  input  wire logic [7:0]  i_array1_protect_start,
  input  wire logic        i_vector_page_erase,
  // Low power
  input  wire logic        i_standby_req,
  // Array side
  output logic             o_pump_on,
  output logic             o_erase_whole,
  output logic             o_erase_page,
  output logic             o_program_row,
  output logic [15:0]      o_target_addr,
  output logic [7:0]       o_protect_view
);
  typedef struct packed {
    logic        prog;
    logic        erase;
    logic        whole;
    logic        high_voltage_enable;
    logic        prot_read;
    logic        latched;
    logic [15:0] target;
    logic [7:0]  prot;
    logic [7:0]  rdata;
    logic        ack;
  } sfa_dev_st_t;

  sfa_dev_st_t st_r;
  sfa_dev_st_t st_nxt;

  function automatic logic in_array(input logic [15:0] a);
    in_array = (a >= SFA_W0_LO && a <= SFA_W0_HI) || (a >= SFA_W1_LO && a <= SFA_W1_HI)
            || (a >= SFA_W2_LO && a <= SFA_W2_HI);
  endfunction

  function automatic logic [15:0] prot_start(input logic [7:0] p);
    if (p == SFA_PROT_TOP2) prot_start = SFA_TOP2_START;
    else prot_start = {1'b0, p, 7'h00};
  endfunction

  function automatic logic is_protected(input logic [7:0] p, input logic [15:0] a);
    // Unimplemented low addresses simply fall under the range
    if (p == SFA_PROT_OPEN) is_protected = 1'b0;
    else is_protected = (a >= prot_start(p)) && (a <= SFA_W2_HI);
  endfunction

  logic       wr;
  logic       rd;
  logic [7:0] wctl;
  logic       hv_ok;
  assign wr    = bus.req && bus.we && !st_r.ack;
  assign rd    = bus.req && !bus.we && !st_r.ack;
  assign wctl  = bus.wdata;
  always_comb begin
    hv_ok = 1'b0;
    if ((st_r.prog || st_r.erase) && st_r.prot_read && st_r.latched) begin
      if (st_r.erase && st_r.whole) hv_ok = (st_r.prot == SFA_PROT_OPEN);
      else hv_ok = !is_protected(st_r.prot, st_r.target);
    end
  end

  always_comb begin
    st_nxt       = st_r;
    st_nxt.ack   = 1'b0;
    st_nxt.prot  = i_vector_page_erase ? SFA_PROT_OPEN : i_array1_protect_start;
    if (bus.req && !st_r.ack) st_nxt.ack = 1'b1;
    if (wr && bus.addr == SFA_CTRL_ADDR) begin
      if (!(wctl[SFA_BIT_PROG] && wctl[SFA_BIT_ERASE])) begin
        st_nxt.prog  = wctl[SFA_BIT_PROG];
        st_nxt.erase = wctl[SFA_BIT_ERASE];
      end
      st_nxt.whole = wctl[SFA_BIT_WHOLE];
      if (!wctl[SFA_BIT_HIGH_VOLTAGE_ENABLE]) st_nxt.high_voltage_enable = 1'b0;
      else if (hv_ok) st_nxt.high_voltage_enable = 1'b1;
      if (!st_nxt.prog && !st_nxt.erase) begin
        st_nxt.prot_read = 1'b0;
        st_nxt.latched   = 1'b0;
      end
    end else if (wr && in_array(bus.addr) && (st_r.prog || st_r.erase) && !st_r.high_voltage_enable) begin
      st_nxt.latched = 1'b1;
      st_nxt.target  = bus.addr;
    end
    if (rd) begin
      st_nxt.rdata = SFA_ERASED_BYTE;
      if (bus.addr == SFA_CTRL_ADDR) begin
        st_nxt.rdata = 8'h00;
        st_nxt.rdata[SFA_BIT_PROG]  = st_r.prog;
        st_nxt.rdata[SFA_BIT_ERASE] = st_r.erase;
        st_nxt.rdata[SFA_BIT_WHOLE] = st_r.whole;
        st_nxt.rdata[SFA_BIT_HIGH_VOLTAGE_ENABLE]  = st_r.high_voltage_enable;
      end else if (bus.addr == SFA_PROT_ADDR) begin
        st_nxt.rdata = st_r.prot;
        if (st_r.prog || st_r.erase) st_nxt.prot_read = 1'b1;
      end
    end
    if (i_standby_req) begin
      st_nxt.high_voltage_enable = 1'b0;
    end
    if (i_reset) begin
      st_nxt = '0;
      st_nxt.prot = SFA_PROT_OPEN;
    end
  end

  always_ff @(posedge i_mclk) begin
    st_r <= st_nxt;
  end

  // Array drive: whole cycle gated by standby; target is the latched array write address, or SFA_W0_LO when whole is set
  logic pump_nxt;
  assign pump_nxt = st_nxt.high_voltage_enable && !i_standby_req;
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_pump_on      <= 1'b0;
      o_erase_whole  <= 1'b0;
      o_erase_page   <= 1'b0;
      o_program_row  <= 1'b0;
      o_target_addr  <= 16'h0000;
      o_protect_view <= SFA_PROT_OPEN;
    end else begin
      o_pump_on      <= pump_nxt;
      o_erase_whole  <= pump_nxt && st_nxt.erase && st_nxt.whole;
      o_erase_page   <= pump_nxt && st_nxt.erase && !st_nxt.whole;
      o_program_row  <= pump_nxt && st_nxt.prog;
      o_target_addr  <= st_nxt.whole ? SFA_W0_LO : st_nxt.target;
      o_protect_view <= st_nxt.prot;
    end
  end
  assign bus.ack   = st_r.ack;
  assign bus.rdata = st_r.rdata;
endmodule // sfa_dev

// [hw/sfa_if.sv]
// Interface: CPU-side bus between controller and flash array control
`timescale 1ns/1ps
interface sfa_if;
  logic        req;
  logic        we;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        ack;
  modport ctrl (output req, output we, output addr, output wdata, input rdata, input ack);
  modport dev  (input req, input we, input addr, input wdata, output rdata, output ack);
endinterface

// [hw/sfa_pkg.sv]
// Package: constants for the second flash array control link
package sfa_pkg;
  // Register map of the device (16-bit CPU addresses)
  localparam logic [15:0] SFA_CTRL_ADDR    = 16'hfe08;
  localparam logic [15:0] SFA_PROT_ADDR    = 16'hff81;
  // Control register bit positions
  localparam int          SFA_BIT_PROG     = 0;
  localparam int          SFA_BIT_ERASE    = 1;
  localparam int          SFA_BIT_WHOLE    = 2;
  localparam int          SFA_BIT_HIGH_VOLTAGE_ENABLE     = 3;
  localparam logic [7:0]  SFA_CTRL_RESET   = 8'h00;
  // Protect byte codes
  localparam logic [7:0]  SFA_PROT_OPEN    = 8'hff;
  localparam logic [7:0]  SFA_PROT_TOP2    = 8'hfe;
  localparam logic [15:0] SFA_TOP2_START   = 16'h7f00;
  // Array windows
  localparam logic [15:0] SFA_W0_LO        = 16'h0462;
  localparam logic [15:0] SFA_W0_HI        = 16'h04ff;
  localparam logic [15:0] SFA_W1_LO        = 16'h0980;
  localparam logic [15:0] SFA_W1_HI        = 16'h1b7f;
  localparam logic [15:0] SFA_W2_LO        = 16'h1e20;
  localparam logic [15:0] SFA_W2_HI        = 16'h7fff;
  localparam int          SFA_ROW_BYTES    = 64;
  localparam int          SFA_PAGE_BYTES   = 128;
  localparam int          SFA_PAGE_LSB     = 7;
  localparam logic [7:0]  SFA_ERASED_BYTE  = 8'hff;
  // Timing, 25 MHz clock
  localparam int          SFA_CLK_KHZ      = 25000;
  localparam int          SFA_SETUP_NS     = 10000;
  localparam int          SFA_WHOLE_US     = 4000;
  localparam int          SFA_HOLD_US      = 100;
  localparam int          SFA_RECOV_NS     = 1000;
  localparam int          SFA_SETUP_CYC    = (SFA_SETUP_NS * SFA_CLK_KHZ + 999999) / 1000000;
  localparam int          SFA_WHOLE_CYC    = (SFA_WHOLE_US * SFA_CLK_KHZ + 999) / 1000;
  localparam int          SFA_HOLD_CYC     = (SFA_HOLD_US * SFA_CLK_KHZ + 999) / 1000;
  localparam int          SFA_RECOV_CYC    = (SFA_RECOV_NS * SFA_CLK_KHZ + 999999) / 1000000;
  localparam int          SFA_CNT_W        = 20;
  // Controller register offsets (AXI4-Lite byte addresses)
  localparam logic [3:0]  SFA_AX_CMD       = 4'h0;
  localparam logic [3:0]  SFA_AX_STAT      = 4'h4;
  localparam logic [3:0]  SFA_AX_ADDR      = 4'h8;
  localparam logic [1:0]  SFA_RESP_OKAY    = 2'b00;
  localparam logic [1:0]  SFA_RESP_SLVERR  = 2'b10;
  // Controller commands
  localparam logic [1:0]  SFA_CMD_WHOLE    = 2'h1;
  localparam logic [1:0]  SFA_CMD_PAGE     = 2'h2;
endpackage

// [test/sfa_asserts.sv]
// Checker: handshake and erase sequence rules on the array bus
`timescale 1ns/1ps
module sfa_asserts
  import sfa_pkg::*;
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  // Array bus
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic [7:0]  rdata,
  input  wire logic        ack
);
  // ****************************************
  // Sequence tracking
  // ****************************************
  int         gap_r;
  logic       hv_r;
  logic       prd_r;
  logic       awr_r;
  logic [7:0] pv_r;
  logic       tk;
  assign tk = req && !ack;
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      gap_r <= 0;
      hv_r  <= 1'b0;
      prd_r <= 1'b0;
      awr_r <= 1'b0;
      pv_r  <= 8'h00;
    end else begin
      gap_r <= (tk && we) ? 0 : gap_r + 1;
      if (tk && we && addr == SFA_CTRL_ADDR) begin
        hv_r <= wdata[SFA_BIT_HIGH_VOLTAGE_ENABLE];
        if (!wdata[SFA_BIT_HIGH_VOLTAGE_ENABLE]) begin
          prd_r <= 1'b0;
          awr_r <= 1'b0;
        end
      end
      if (tk && !we && addr == SFA_PROT_ADDR) prd_r <= 1'b1;
      if (tk && we && addr != SFA_CTRL_ADDR) awr_r <= 1'b1;
      if (ack && !we && addr == SFA_PROT_ADDR) pv_r <= rdata;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  sequence s_ctl_wr;
    tk && we && addr == SFA_CTRL_ADDR;
  endsequence
  sequence s_ctl_rd;
    ack && !we && addr == SFA_CTRL_ADDR;
  endsequence
  chk_req_held: assert property (tk |=> req && $stable(addr) && $stable(we) && $stable(wdata))
    else $error("request changed before ack");
  chk_ack_next: assert property (tk |=> ack)
    else $error("ack not one cycle after request");
  chk_ack_pulse: assert property (ack |=> !ack && !req)
    else $error("ack or request held too long");
  chk_sel_excl: assert property (
    s_ctl_rd |-> !(rdata[SFA_BIT_PROG] && rdata[SFA_BIT_ERASE]))
    else $error("program and erase both selected");
  chk_hv_order: assert property (
    s_ctl_wr ##0 (wdata[SFA_BIT_HIGH_VOLTAGE_ENABLE] && !hv_r) |-> prd_r && awr_r)
    else $error("high voltage set before protect read or array write");
  chk_setup_wait: assert property (
    s_ctl_wr ##0 (wdata[SFA_BIT_HIGH_VOLTAGE_ENABLE] && !hv_r && pv_r == SFA_PROT_OPEN)
    |-> gap_r >= SFA_SETUP_CYC - 1)
    else $error("setup wait too short");
  chk_erase_time: assert property (
    s_ctl_wr ##0 (hv_r && wdata[SFA_BIT_HIGH_VOLTAGE_ENABLE] && !wdata[SFA_BIT_ERASE] && pv_r == SFA_PROT_OPEN)
    |-> gap_r >= SFA_WHOLE_CYC - 1)
    else $error("erase time too short");
  chk_hold_time: assert property (
    s_ctl_wr ##0 (hv_r && !wdata[SFA_BIT_HIGH_VOLTAGE_ENABLE] && pv_r == SFA_PROT_OPEN)
    |-> gap_r >= SFA_HOLD_CYC - 1)
    else $error("hold time too short");
  chk_mass_lock: assert property (
    s_ctl_rd ##0 (rdata[SFA_BIT_HIGH_VOLTAGE_ENABLE] && rdata[SFA_BIT_WHOLE]) |-> pv_r == SFA_PROT_OPEN)
    else $error("whole erase with protection set");
endmodule // sfa_asserts

// [test/tb.sv]
// Testbench: controller and array control joined over the array bus
`timescale 1ns/1ps
module tb;
  import sfa_pkg::*;
  logic        clk, rst, awv, wv, brdy, arv, rrdy, vpe, sby;
  logic        awrdy, wrdy, bv, arrdy, rv, pump, ew, ews;
  logic [3:0]  awa, ara;
  logic [31:0] wd, rdat, d;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  prot, pv;
  logic [7:0]  codes [3] = '{8'h00, 8'hfe, 8'h7f};
  int          pc, pc0, compares, mismatches;
  sfa_if i_sfa_if ();
  sfa_ctrl i_sfa_ctrl (.i_mclk(clk), .i_reset(rst), .i_awaddr(awa), .i_awvalid(awv),
    .o_awready(awrdy), .i_wdata(wd), .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wrdy),
    .o_bresp(bresp), .o_bvalid(bv), .i_bready(brdy), .i_araddr(ara), .i_arvalid(arv),
    .o_arready(arrdy), .o_rdata(rdat), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rrdy),
    .bus(i_sfa_if.ctrl));
  sfa_dev i_sfa_dev (.i_mclk(clk), .i_reset(rst), .bus(i_sfa_if.dev),
    .i_array1_protect_start(prot), .i_vector_page_erase(vpe), .i_standby_req(sby),
    .o_pump_on(pump), .o_erase_whole(ew), .o_erase_page(), .o_program_row(),
    .o_target_addr(), .o_protect_view(pv));
  sfa_asserts chk (.i_mclk(clk), .i_reset(rst), .req(i_sfa_if.req), .we(i_sfa_if.we),
    .addr(i_sfa_if.addr), .wdata(i_sfa_if.wdata), .rdata(i_sfa_if.rdata), .ack(i_sfa_if.ack));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk_v(input logic [31:0] s, input logic [31:0] e, input string m);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value at %0t ns: %s", $time, m);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; brdy <= 1'b1;
    do @(posedge clk); while (awrdy !== 1'b1);
    awv <= 1'b0; wv <= 1'b0;
    do @(posedge clk); while (bv !== 1'b1);
    brdy <= 1'b0;
    chk_v({30'h0, bresp}, {30'h0, SFA_RESP_OKAY}, "write response");
  endtask
  task automatic axr(input logic [3:0] a);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rrdy <= 1'b1;
    do @(posedge clk); while (arrdy !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rrdy <= 1'b0; d = rdat; r = rresp;
  endtask
  task automatic go(input logic [15:0] a);
    axw(SFA_AX_ADDR, {16'h0, a});
    axw(SFA_AX_CMD, {30'h0, SFA_CMD_WHOLE});
    d = 32'h1;
    while (d[0] !== 1'b0) axr(SFA_AX_STAT);
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****************************************
  // Clock, monitor, watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rst) begin
      pc  <= 0;
      ews <= 1'b0;
    end else begin
      if (pump === 1'b1) pc <= pc + 1;
      if (pump === 1'b1 && ew === 1'b1) ews <= 1'b1;
    end
  end
  initial begin
    repeat (120000) @(posedge clk);
    mismatches++;
    close_out;
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst = 1'b1; awv = 1'b0; wv = 1'b0; brdy = 1'b0; arv = 1'b0; rrdy = 1'b0; vpe = 1'b0;
    sby = 1'b0; awa = 4'h0; ara = 4'h0; wd = 32'h0; prot = 8'hff; pc0 = 0;
    compares = 0; mismatches = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    axr(SFA_AX_STAT);
    chk_v({21'h0, d[10:0]}, 32'h0, "status after reset");
    chk_v({31'h0, pump}, 32'h0, "pump after reset");
    axr(4'hc);
    chk_v({30'h0, r}, {30'h0, SFA_RESP_SLVERR}, "unmapped read");
    $display("test reset done");
    prot <= 8'h00;
    repeat (3) @(posedge clk);
    chk_v({24'h0, pv}, 32'h0, "protect follows other array");
    vpe <= 1'b1;
    repeat (3) @(posedge clk);
    chk_v({24'h0, pv}, {24'h0, SFA_PROT_OPEN}, "vector erase protect");
    vpe <= 1'b0;
    $display("test protect source done");
    foreach (codes[i]) begin
      prot <= codes[i];
      pc0 = pc;
      go(SFA_W2_LO);
      chk_v({31'h0, d[2]}, 32'h1, "blocked erase flag");
      chk_v(pc - pc0, 0, "pump ran while protected");
      chk_v({24'h0, d[10:3]}, {24'h0, codes[i]}, "protect in status");
    end
    $display("test blocked erase done");
    prot <= SFA_PROT_OPEN;
    axw(SFA_AX_ADDR, {16'h0, SFA_W0_LO});
    axw(SFA_AX_CMD, {30'h0, SFA_CMD_WHOLE});
    while (pump !== 1'b1) @(posedge clk);
    sby <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b1;
    chk_v({30'h0, pump, ew}, 32'h0, "standby outputs");
    repeat (20) @(posedge clk);
    rst <= 1'b0; sby <= 1'b0;
    axr(SFA_AX_STAT);
    chk_v({31'h0, d[0]}, 32'h0, "idle after second reset");
    $display("test standby done");
    pc0 = pc;
    go(SFA_W1_LO);
    chk_v({30'h0, d[2:1]}, 32'h1, "whole erase done flag");
    chk_v({31'h0, ews}, 32'h1, "whole erase selected");
    chk_v(pc - pc0 >= SFA_WHOLE_CYC + SFA_HOLD_CYC, 1, "high voltage time");
    chk_v({31'h0, pump}, 32'h0, "pump off after erase");
    $display("test whole erase done");
    close_out;
  end
endmodule // tb
